/* File: src/twsdc_top.sv */
// three-wire serial loaded divider control with reference divider,
// phase/frequency comparator and lock flag, plus a wishbone register slave
// assumes every pin is asynchronous to clk and far slower than 25 MHz
//
// How it works
// - serial bits shift in only while enable is high
// - serial clock edges are ignored while enable is low
// - holding buffers load only on a falling enable edge
// - one 18 or 19 bit word carries divisor and port bits
// - divisor is 14 or 15 bits wide depending on mode
// - mode high: divisor msb bypassed, compare at 7.8125 kHz
// - mode low: full divisor width, compare at 3.90625 kHz
// - comparison frequencies come from the 4 MHz oscillator input
// - input passes a fixed divide-by-8 before the programmable divider
// - comparator checks phase and frequency and drives the charge pump
// - lock flag pulls low when locked, floats when out of lock
// - four open-collector port outputs follow the four port bits
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ns
module twsdc_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [twsdc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serData,
  input wire logic serClk,
  input wire logic serEnable,
  input wire logic modeSel,
  input wire logic oscIn,
  input wire logic rfIn,
  output logic [twsdc_pkg::PORT_W-1:0] portOutputLines,
  output logic [twsdc_pkg::PORT_W-1:0] portOeN,
  output logic lockOut,
  output logic lockOeN,
  output logic pumpUp,
  output logic pumpDown,
  output logic dividerOutputFreq,
  output logic irq
);

  logic [twsdc_pkg::PIN_N-1:0] pinRaw;
  logic [twsdc_pkg::PIN_N-1:0] sync1_r;
  logic [twsdc_pkg::PIN_N-1:0] sync2_r;
  logic [twsdc_pkg::PIN_N-1:0] prev_r;
  logic [twsdc_pkg::PIN_N-1:0] rise;
  logic enHigh;
  logic enFall;
  logic mode1;
  logic [twsdc_pkg::WORD_W-1:0] shift_r;
  logic [twsdc_pkg::DIV_W-1:0] divisor_r;
  logic [twsdc_pkg::PORT_W-1:0] ports_r;
  logic loadPulse;
  logic [twsdc_pkg::PRESC_W-1:0] presc_r;
  logic prescPulse;
  logic [twsdc_pkg::DIV_W-1:0] divCnt_r;
  logic [twsdc_pkg::DIV_W-1:0] divEff;
  logic [twsdc_pkg::DIV_W-1:0] divLast;
  logic divPulse;
  logic [twsdc_pkg::REF_W-1:0] refCnt_r;
  logic [twsdc_pkg::REF_W-1:0] refLast;
  logic refPulse;
  logic up_r;
  logic down_r;
  logic [twsdc_pkg::WIN_W-1:0] width_r;
  logic [twsdc_pkg::WIN_W-1:0] widthMax_r;
  logic [twsdc_pkg::GOOD_W-1:0] good_r;
  logic locked_r;
  logic lockedPrev_r;
  logic pumpDis_r;
  logic [twsdc_pkg::IRQ_W-1:0] irqStat_r;
  logic [twsdc_pkg::IRQ_W-1:0] irqMask_r;
  logic [twsdc_pkg::IRQ_W-1:0] irqSet;
  logic wbReq;
  logic wbWrite;
  logic wbRead;
  logic [31:0] rdData;

  assign pinRaw = {rfIn, oscIn, modeSel, serEnable, serClk, serData};

  // two-flop synchronisers; the first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pinRaw;
      sync2_r <= sync1_r;
    end
  end

  // edge history taken from the settled stage only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_r <= '0;
    end else begin
      prev_r <= sync2_r;
    end
  end

  assign rise = sync2_r & ~prev_r;
  assign enHigh = sync2_r[twsdc_pkg::PIN_EN];
  assign enFall = prev_r[twsdc_pkg::PIN_EN] & ~sync2_r[twsdc_pkg::PIN_EN];
  assign mode1 = sync2_r[twsdc_pkg::PIN_MODE];

  // serial shift register; data and clock share the same sync delay,
  // so the sampled bit is the one that stood at the serial clock edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_r <= '0;
    end else if (enHigh && rise[twsdc_pkg::PIN_SCLK]) begin
      shift_r <= {shift_r[twsdc_pkg::WORD_W-2:0], sync2_r[twsdc_pkg::PIN_DATA]};
    end
  end

  // holding buffers; extra leading bits simply fall off the top,
  // so only the last 18 or 19 bits of a burst count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divisor_r <= '0;
      ports_r <= '0;
      loadPulse <= 1'b0;
    end else if (enFall) begin
      ports_r <= shift_r[twsdc_pkg::PORT_LSB +: twsdc_pkg::PORT_W];
      if (mode1) begin
        divisor_r <= {1'b0, shift_r[twsdc_pkg::DIV_LSB +: twsdc_pkg::MODE1_DIV_W]};
      end else begin
        divisor_r <= shift_r[twsdc_pkg::DIV_LSB +: twsdc_pkg::DIV_W];
      end
      loadPulse <= 1'b1;
    end else begin
      loadPulse <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_r <= '0;
      prescPulse <= 1'b0;
    end else if (rise[twsdc_pkg::PIN_RF]) begin
      presc_r <= presc_r + 1'b1;
      prescPulse <= (presc_r == twsdc_pkg::PRESC_LAST);
    end else begin
      prescPulse <= 1'b0;
    end
  end

  assign divEff = mode1 ? (divisor_r & twsdc_pkg::MODE1_DIV_MASK) : divisor_r;
  // a divisor of zero or one behaves as divide by one
  assign divLast = (divEff == '0) ? '0 : divEff - 1'b1;

  // programmable divider, one output pulse per divEff prescaler pulses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt_r <= '0;
      divPulse <= 1'b0;
    end else if (prescPulse) begin
      // >= so that a smaller new divisor cannot strand the count
      if (divCnt_r >= divLast) begin
        divCnt_r <= '0;
        divPulse <= 1'b1;
      end else begin
        divCnt_r <= divCnt_r + 1'b1;
        divPulse <= 1'b0;
      end
    end else begin
      divPulse <= 1'b0;
    end
  end

  assign refLast = mode1 ? twsdc_pkg::REF_LAST_MODE1 : twsdc_pkg::REF_LAST_MODE2;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      refCnt_r <= '0;
      refPulse <= 1'b0;
    end else if (rise[twsdc_pkg::PIN_OSC]) begin
      if (refCnt_r >= refLast) begin
        refCnt_r <= '0;
        refPulse <= 1'b1;
      end else begin
        refCnt_r <= refCnt_r + 1'b1;
        refPulse <= 1'b0;
      end
    end else begin
      refPulse <= 1'b0;
    end
  end

  // phase frequency detector
  // classic two-flop detector: the leading edge raises its side, the
  // lagging edge clears both, so frequency error keeps one side high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      up_r <= 1'b0;
      down_r <= 1'b0;
    end else if ((up_r || refPulse) && (down_r || divPulse)) begin
      up_r <= 1'b0;
      down_r <= 1'b0;
    end else begin
      up_r <= up_r | refPulse;
      down_r <= down_r | divPulse;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pumpUp <= 1'b0;
      pumpDown <= 1'b0;
      dividerOutputFreq <= 1'b0;
    end else begin
      pumpUp <= up_r & ~pumpDis_r;
      pumpDown <= down_r & ~pumpDis_r;
      dividerOutputFreq <= divPulse;
    end
  end

  // widest pump pulse in each reference period; saturates at the top
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      width_r <= '0;
      widthMax_r <= '0;
    end else begin
      if (up_r || down_r) begin
        width_r <= (width_r == '1) ? width_r : width_r + 1'b1;
      end else begin
        width_r <= '0;
      end
      if (refPulse) begin
        widthMax_r <= '0;
      end else if (width_r > widthMax_r) begin
        widthMax_r <= width_r;
      end
    end
  end

  // lock after consecutive narrow periods
  // a single wide period drops lock at once, so the flag is slow to
  // rise and quick to fall
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      good_r <= '0;
      locked_r <= 1'b0;
      lockedPrev_r <= 1'b0;
    end else begin
      lockedPrev_r <= locked_r;
      if (refPulse) begin
        if (widthMax_r < twsdc_pkg::LOCK_WIN_CYC && !(up_r && width_r >= widthMax_r
            && width_r >= twsdc_pkg::LOCK_WIN_CYC)) begin
          if (good_r != twsdc_pkg::LOCK_GOOD_CNT) begin
            good_r <= good_r + 1'b1;
          end
          locked_r <= (good_r >= twsdc_pkg::LOCK_GOOD_CNT - 1'b1);
        end else begin
          good_r <= '0;
          locked_r <= 1'b0;
        end
      end
    end
  end

  assign lockOut = 1'b0;
  assign lockOeN = ~locked_r;

  // open collector ports
  // a set port bit sinks current; a clear one floats
  assign portOutputLines = '0;
  assign portOeN = ~ports_r;

  // wishbone classic slave: ack one cycle after the strobe, then drop
  assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWrite = wbReq & wb_we_i;
  assign wbRead = wbReq & ~wb_we_i;

  // read mux; unmapped addresses read zero
  always_comb begin
    rdData = '0;
    unique case (wb_adr_i)
      twsdc_pkg::ADDR_CTRL: rdData[twsdc_pkg::CTRL_PUMP_DIS] = pumpDis_r;
      twsdc_pkg::ADDR_STATUS: begin
        rdData[twsdc_pkg::STAT_DIV_LSB +: twsdc_pkg::DIV_W] = divisor_r;
        rdData[twsdc_pkg::STAT_PORT_LSB +: twsdc_pkg::PORT_W] = ports_r;
        rdData[twsdc_pkg::STAT_MODE_BIT] = mode1;
        rdData[twsdc_pkg::STAT_LOCK_BIT] = locked_r;
      end
      twsdc_pkg::ADDR_IRQ_STAT: rdData[twsdc_pkg::IRQ_W-1:0] = irqStat_r;
      twsdc_pkg::ADDR_IRQ_MASK: rdData[twsdc_pkg::IRQ_W-1:0] = irqMask_r;
      default: rdData = '0;
    endcase
  end

  // bus answer and read data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wbReq;
      if (wbRead) begin
        wb_dat_o <= rdData;
      end
    end
  end

  // writable control and mask; only byte lane 0 carries bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pumpDis_r <= twsdc_pkg::CTRL_RESET;
      irqMask_r <= twsdc_pkg::IRQ_RESET;
    end else if (wbWrite && wb_sel_i[0]) begin
      if (wb_adr_i == twsdc_pkg::ADDR_CTRL) begin
        pumpDis_r <= wb_dat_i[twsdc_pkg::CTRL_PUMP_DIS];
      end
      if (wb_adr_i == twsdc_pkg::ADDR_IRQ_MASK) begin
        irqMask_r <= wb_dat_i[twsdc_pkg::IRQ_W-1:0];
      end
    end
  end

  // sticky events: word loaded, lock gained, lock lost
  always_comb begin
    irqSet = '0;
    irqSet[twsdc_pkg::IRQ_LOADED] = loadPulse;
    irqSet[twsdc_pkg::IRQ_LOCK] = locked_r & ~lockedPrev_r;
    irqSet[twsdc_pkg::IRQ_UNLOCK] = ~locked_r & lockedPrev_r;
  end

  // read clears the status; an event in the same cycle survives the clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStat_r <= twsdc_pkg::IRQ_RESET;
    end else if (wbRead && wb_adr_i == twsdc_pkg::ADDR_IRQ_STAT) begin
      irqStat_r <= irqSet;
    end else begin
      irqStat_r <= irqStat_r | irqSet;
    end
  end

  // level interrupt while any unmasked bit stands
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_r & irqMask_r);
    end
  end

endmodule : twsdc_top

/* File: src/twsdc_pkg.sv */
// constants for the three-wire synthesizer divider control block
// assumes a single 50 MHz system clock; all pins are sampled by it
package twsdc_pkg;

  // system clock
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;

  // serial word layout: divisor msb first, then the four port bits
  localparam int DIV_W = 15;
  localparam int MODE1_DIV_W = 14;
  localparam int PORT_W = 4;
  localparam int WORD_W = DIV_W + PORT_W;
  localparam int PORT_LSB = 0;
  localparam int DIV_LSB = PORT_W;
  localparam logic [DIV_W-1:0] MODE1_DIV_MASK = 15'h3FFF;

  // fixed prescaler ahead of the programmable divider
  localparam int PRESCALE = 8;
  localparam int PRESC_W = 3;
  localparam logic [PRESC_W-1:0] PRESC_LAST = 3'h7;

  // reference divider from the 4 MHz oscillator
  localparam int OSC_HZ = 4_000_000;
  localparam int REF_W = 10;
  localparam logic [REF_W-1:0] REF_LAST_MODE1 = 10'h1FF; // divide by 512
  localparam logic [REF_W-1:0] REF_LAST_MODE2 = 10'h3FF; // divide by 1024

  // lock detector: pump pulses shorter than the window count as in lock
  localparam int LOCK_WIN_NS = 1000;
  localparam int LOCK_WIN_CYC_I = LOCK_WIN_NS / CLK_PERIOD_NS;
  localparam int WIN_W = 8;
  localparam logic [WIN_W-1:0] LOCK_WIN_CYC = LOCK_WIN_CYC_I[WIN_W-1:0];
  localparam int GOOD_W = 3;
  localparam logic [GOOD_W-1:0] LOCK_GOOD_CNT = 3'h4;

  // synchronised pin vector positions
  localparam int PIN_N = 6;
  localparam int PIN_DATA = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_EN = 2;
  localparam int PIN_MODE = 3;
  localparam int PIN_OSC = 4;
  localparam int PIN_RF = 5;

  // register map, byte addresses
  localparam int ADR_W = 4;
  localparam logic [ADR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADR_W-1:0] ADDR_STATUS = 4'h4;
  localparam logic [ADR_W-1:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [ADR_W-1:0] ADDR_IRQ_MASK = 4'hC;

  // control register
  localparam int CTRL_PUMP_DIS = 0;
  localparam logic CTRL_RESET = 1'h0;

  // status register fields
  localparam int STAT_DIV_LSB = 0;
  localparam int STAT_PORT_LSB = 16;
  localparam int STAT_MODE_BIT = 20;
  localparam int STAT_LOCK_BIT = 21;

  // interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_LOADED = 0;
  localparam int IRQ_LOCK = 1;
  localparam int IRQ_UNLOCK = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

endpackage : twsdc_pkg

/* File: verification/twsdc_asserts.sv */
// port checker for the divider control top
// assumes one clock domain; bound by name at the foot
`timescale 1ns/1ns
module twsdc_asserts (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic serEnable,
  input wire logic [3:0] portOutputLines,
  input wire logic [3:0] portOeN,
  input wire logic lockOut,
  input wire logic dividerOutputFreq,
  input wire logic irq
);
  logic [3:0] quietCnt;
  logic enLast;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // cycles since the enable pin last moved; saturates so long idles stay legal
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      quietCnt <= 4'h0;
      enLast <= 1'b0;
    end else begin
      enLast <= serEnable;
      if (serEnable != enLast) quietCnt <= 4'h0;
      else if (quietCnt != 4'hF) quietCnt <= quietCnt + 4'h1;
    end
  end

  ack_one_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  rdata_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved outside a read");
  ports_quiet_a: assert property (quietCnt == 4'hF |-> $stable(portOeN))
    else $error("ports moved with enable idle");
  ports_enlow_a: assert property ($changed(portOeN) |-> !serEnable)
    else $error("ports moved while enable high");
  open_drain_a: assert property (lockOut == 1'b0 && portOutputLines == 4'h0)
    else $error("open drain data not low");
  div_pulse_a: assert property (dividerOutputFreq |=> !dividerOutputFreq)
    else $error("divider pulse too wide");

  cover property ($changed(portOeN));
  cover property (wb_ack_o && !wb_we_i);
  cover property (dividerOutputFreq);
  cover property ($rose(irq));
endmodule : twsdc_asserts

bind twsdc_top twsdc_asserts i_twsdc_asserts (
  .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .serEnable(serEnable), .portOutputLines(portOutputLines), .portOeN(portOeN),
  .lockOut(lockOut), .dividerOutputFreq(dividerOutputFreq), .irq(irq)
);

/* File: verification/twsdc_host_model.sv */
// host side of the three-wire bus: data, link clock, enable
// assumes pacing by the system clock; link clock period 160 ns
`timescale 1ns/1ns
module twsdc_host_model (
  input wire logic clk,
  output logic serData,
  output logic serClk,
  output logic serEnable
);
  // idle bus; the link clock starts low and moves only in shiftBits
  initial begin
    serData = 1'b0;
    serClk = 1'b0;
    serEnable = 1'b0;
  end

  // enable held high around the whole word, long margins both sides
  task automatic setEnable(input logic v);
    repeat (8) @(posedge clk);
    serEnable <= v;
    // released data line shows the inverse of its last level
    if (!v) serData <= ~serData;
    repeat (8) @(posedge clk);
  endtask : setEnable

  // one word, msb first: 18 bits in mode 1, 19 in mode 2
  task automatic shiftBits(input logic [18:0] w, input logic mode1);
    for (int i = mode1 ? 17 : 18; i >= 0; i--) begin
      @(posedge clk);
      serData <= w[i];
      repeat (3) @(posedge clk);
      serClk <= 1'b1;
      repeat (4) @(posedge clk);
      serClk <= 1'b0;
    end
  endtask : shiftBits
endmodule : twsdc_host_model

/* File: verification/tb.sv */
// self-checking bench for the divider control top
// assumes the host model drives the three-wire pins
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic arstN = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, modeSel = 1'b0;
  logic oscIn = 1'b0, rfIn = 1'b0, rfRun = 1'b0, rfTrack = 1'b0;
  logic [3:0] wbAdr = 4'h0, wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0000_0000;
  logic [31:0] wbDatO, q;
  logic wbAck, serData, serClk, serEnable, lockOut, lockOeN, pumpUp, pumpDown, divOut, irq;
  logic [3:0] portLines, portOeN;
  logic [1:0] rfPh = 2'h0;
  logic [2:0] oscPh = 3'h0;
  int seed = 4;
  int numErrors = 0;
  int totalChecks = 0;

  twsdc_top i_twsdc_top (
    .clk(clk), .arst_n(arstN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .serData(serData), .serClk(serClk), .serEnable(serEnable),
    .modeSel(modeSel), .oscIn(oscIn), .rfIn(rfIn), .portOutputLines(portLines),
    .portOeN(portOeN), .lockOut(lockOut), .lockOeN(lockOeN), .pumpUp(pumpUp),
    .pumpDown(pumpDown), .dividerOutputFreq(divOut), .irq(irq)
  );
  twsdc_host_model i_twsdc_host_model (
    .clk(clk), .serData(serData), .serClk(serClk), .serEnable(serEnable)
  );

  // 50 MHz system clock
  always #10 clk = ~clk;

  // oscillator near 4 MHz, gated rf input at 12.5 MHz; when tracking, the
  // pump steers rf like a vco: up doubles its rate, down stalls it
  always @(posedge clk) begin
    oscPh <= (oscPh == 3'h5) ? 3'h0 : oscPh + 3'h1;
    if (oscPh == 3'h5) oscIn <= ~oscIn;
    rfPh <= rfPh + 2'h1;
    if (rfRun && (rfTrack ? (pumpUp || (rfPh[0] && !pumpDown)) : rfPh[0])) rfIn <= ~rfIn;
  end

  task automatic chk(input logic ok, input string m);
    totalChecks++;
    if (ok !== 1'b1) begin
      numErrors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  task automatic testDone;
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : testDone

  // classic single cycle; held until ack is sampled high
  task automatic wbXfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] r);
    int n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbSel <= 4'hF;
    wbDatI <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    r = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    chk(n < 50, "no ack");
  endtask : wbXfer

  // one word; ports must hold until enable falls
  task automatic load(input logic [14:0] d, input logic [3:0] p);
    logic [3:0] old;
    old = portOeN;
    i_twsdc_host_model.setEnable(1'b1);
    i_twsdc_host_model.shiftBits({d, p}, modeSel);
    chk(portOeN === old, "ports before enable fell");
    i_twsdc_host_model.setEnable(1'b0);
    chk(portOeN === ~p, "port enables");
  endtask : load

  task automatic waitPulse(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (divOut !== 1'b1 && n < 4000);
  endtask : waitPulse

  function automatic int expPer(input logic [14:0] d, input logic m);
    logic [14:0] e;
    e = m ? {1'b0, d[13:0]} : d;
    return (e < 15'h0002) ? 32 : 32 * e;
  endfunction : expPer

  // hang guard, well past the expected run length
  initial begin
    #1_800_000;
    numErrors++;
    testDone();
  end

  initial begin
    logic [14:0] d;
    logic [3:0] p;
    int n;
    repeat (5) @(posedge clk);
    arstN <= 1'b1;
    @(posedge clk);
    chk(portOeN === 4'hF && lockOeN === 1'b1, "reset levels");
    // random words in both modes, then link clocks with enable low
    for (int k = 0; k < 4; k++) begin
      modeSel <= k[0];
      d = 15'($random(seed));
      p = 4'($random(seed));
      load(d, p);
      wbXfer(1'b0, 4'h4, 32'h0000_0000, q);
      chk(q[13:0] === d[13:0] && q[19:16] === p && q[20] === k[0], "status");
      if (!k[0]) chk(q[14] === d[14], "divisor msb");
      i_twsdc_host_model.shiftBits(~{d, p}, 1'b0);
      // an empty enable window reloads the holding buffers from the shift register as it stands
      i_twsdc_host_model.setEnable(1'b1);
      i_twsdc_host_model.setEnable(1'b0);
      chk(portOeN === ~p, "edges with enable low");
    end
    $display("test words done");
    // divider period follows divisor; mode 1 drops the msb
    rfRun <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      modeSel <= k[0];
      d = k[0] ? 15'h4005 : 15'h0006;
      load(d, 4'h0);
      waitPulse(n);
      waitPulse(n);
      waitPulse(n);
      chk(n == expPer(d, k[0]), "divider period");
    end
    $display("test divider done");
    // load interrupt: masked, unmasked, cleared by read
    wbXfer(1'b0, 4'h8, 32'h0000_0000, q);
    wbXfer(1'b1, 4'hC, 32'h0000_0000, q);
    load(15'h0123, 4'hA);
    chk(irq === 1'b0, "masked irq");
    wbXfer(1'b1, 4'hC, 32'h0000_0001, q);
    wbXfer(1'b0, 4'hC, 32'h0000_0000, q);
    chk(q === 32'h0000_0001 && irq === 1'b1, "mask and irq");
    wbXfer(1'b0, 4'h8, 32'h0000_0000, q);
    chk(q[0] === 1'b1, "loaded flag");
    wbXfer(1'b0, 4'h8, 32'h0000_0000, q);
    chk(q[0] === 1'b0 && irq === 1'b0, "read clears");
    wbXfer(1'b0, 4'h2, 32'h0000_0000, q);
    chk(q === 32'h0000_0000, "unmapped read");
    $display("test irq done");
    // mode 1: 192 x 8 rf cycles match 512 oscillator cycles, so the loop locks
    load(15'h00C0, 4'h0);
    rfTrack <= 1'b1;
    n = 0;
    while (lockOeN !== 1'b0 && n < 60000) begin
      @(posedge clk);
      n++;
    end
    chk(lockOeN === 1'b0 && lockOut === 1'b0, "lock flag");
    wbXfer(1'b0, 4'h4, 32'h0000_0000, q);
    chk(q[21] === 1'b1 && q[13:0] === 14'h00C0, "lock status");
    wbXfer(1'b0, 4'h8, 32'h0000_0000, q);
    chk(q[1] === 1'b1, "lock gained flag");
    $display("test lock done");
    // rf stopped: reference alone drives the pump, loop drops lock
    rfRun <= 1'b0;
    rfTrack <= 1'b0;
    modeSel <= 1'b1;
    repeat (14000) @(posedge clk);
    chk((pumpUp ^ pumpDown) === 1'b1 && lockOeN === 1'b1, "pump stopped");
    wbXfer(1'b0, 4'h8, 32'h0000_0000, q);
    chk(q[2] === 1'b1, "lock lost flag");
    wbXfer(1'b1, 4'h0, 32'h0000_0001, q);
    repeat (3) @(posedge clk);
    chk(pumpUp === 1'b0 && pumpDown === 1'b0, "pump disable");
    $display("test pump done");
    testDone();
  end
endmodule : tb
